// >>> verilog/sbc_pkg.sv
// Constants and types shared by the burst memory command port.
// Assumes one device clock, with the controller driving on the same clock.
// Overview of operation
// (RQ1) All address bits, both lowest too, are sampled at the rising edge.
// (RQ2) Synchronous inputs are captured only at a rising clock edge.
// (RQ3) An edge counts only while the active-low clock gate is low.
// (RQ4) A low write strobe at a counted edge starts a write.
// (RQ5) Each low lane select with a write enables its byte and parity only.
// (RQ6) Advance high at a counted edge steps the burst counter.
// (RQ7) Advance low at a counted edge loads the presented address.
// (RQ8) After deselection the controller must load, never advance.
// (RQ9) First chip select is active low, combined with the other two.
// (RQ10) A high clock gate freezes state and never deselects.
// (RQ11) Strap high gives interleaved order, low gives linear; it stays fixed.
// (RQ12) Data and parity float in write phase, after and during deselection.
// (RQ13) Selected only with first and third selects low, second select high.
package sbc_pkg;
  localparam int         SBC_ADDR_W   = 21;
  localparam int         SBC_LANES    = 4;
  localparam int         SBC_BURST_W  = 2;
  localparam logic [1:0] SBC_BURST_RST = 2'h0;
  localparam logic [1:0] SBC_BURST_ONE = 2'h1;
  localparam logic       SBC_STRAP_RST = 1'h1;

  // Gray path idle -> read -> write
  typedef enum logic [1:0] {
    SBC_IDLE  = 2'b00,
    SBC_READ  = 2'b01,
    SBC_WRITE = 2'b11
  } sbc_op_t;
endpackage

// >>> verilog/sbc_burst_if.sv
// Carries burst counter control and its next low address bits.
// Assumes both ends run on the device clock.
`timescale 1ns/1ps
`default_nettype none
interface sbc_burst_if;
  import sbc_pkg::*;
  logic                   load;
  logic                   advance;
  logic                   interleave;
  logic [SBC_BURST_W-1:0] start_bits;
  logic [SBC_BURST_W-1:0] next_bits;
  modport ctl (output load, output advance, output interleave,
               output start_bits, input next_bits);
  modport cnt (input load, input advance, input interleave,
               input start_bits, output next_bits);
endinterface
`default_nettype wire

// >>> verilog/sbc_burst_counter.sv
// Burst counter: keeps the start bits and the beat count of a burst.
// Assumes load and advance are already qualified by the clock gate.
`timescale 1ns/1ps
`default_nettype none
module sbc_burst_counter
  import sbc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  sbc_burst_if.cnt  bus
);
  logic [SBC_BURST_W-1:0] start_ff;
  logic [SBC_BURST_W-1:0] count_ff;
  logic [SBC_BURST_W-1:0] step;

  always_comb begin
    step = count_ff + SBC_BURST_ONE;
  end

  // Interleaved order toggles bits, linear order adds with wrap
  always_comb begin
    if (bus.interleave) begin // see (RQ11)
      bus.next_bits = start_ff ^ step;
    end else begin
      bus.next_bits = start_ff + step;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_ff <= SBC_BURST_RST;
      count_ff <= SBC_BURST_RST;
    end else if (bus.load) begin // see (RQ7)
      start_ff <= bus.start_bits;
      count_ff <= SBC_BURST_RST;
    end else if (bus.advance) begin // see (RQ6)
      count_ff <= step;
    end else begin
      count_ff <= count_ff;
    end
  end
endmodule // sbc_burst_counter
`default_nettype wire

// >>> verilog/sbc_command_port.sv
// Command front end of a pipelined burst memory: address capture,
// lane write qualification, burst advance or load, select decoding.
// Assumes all command inputs are driven from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module sbc_command_port
  import sbc_pkg::*;
#(
  parameter int ADDR_W = SBC_ADDR_W,
  parameter int LANES  = SBC_LANES
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clock_gate_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [LANES-1:0]  byte_lane_write_sel_n,
  input  wire logic              write_strobe_n,
  input  wire logic              advance_or_load,
  input  wire logic              chip_sel_first_n,
  input  wire logic              chip_sel_second,
  input  wire logic              chip_sel_third_n,
  input  wire logic              burst_order_strap,
  output logic [ADDR_W-1:0]      access_addr_ff,
  output sbc_op_t                cmd_op_ff,
  output logic [LANES-1:0]       lane_write_en_ff,
  output logic [LANES-1:0]       data_lane_wr_ff,
  output logic                   bus_drive_ok_ff,
  output logic                   interleave_ff
);
  sbc_burst_if burst ();

  sbc_op_t          nxt_op;
  sbc_op_t          phase_op_ff;
  logic             edge_ok;
  logic             select_now;
  logic [LANES-1:0] nxt_lanes;

  // Selection decode shared by the command and the checks
  function automatic logic sel_decode(input logic first_n,
                                      input logic second,
                                      input logic third_n);
    sel_decode = !first_n && second && !third_n;
  endfunction

  always_comb begin
    edge_ok    = !clock_gate_n; // see (RQ3)
    select_now = sel_decode(chip_sel_first_n, chip_sel_second,
                            chip_sel_third_n); // see (RQ9) see (RQ13)
  end

  // An advance continues whatever the last load started, including a
  // deselect; the controller is expected to load after deselection.
  always_comb begin
    case (cmd_op_ff)
      SBC_IDLE, SBC_READ, SBC_WRITE: begin
        if (!edge_ok) begin
          nxt_op = cmd_op_ff; // see (RQ10)
        end else if (advance_or_load) begin
          nxt_op = cmd_op_ff; // see (RQ6) see (RQ8)
        end else if (!select_now) begin
          nxt_op = SBC_IDLE; // see (RQ13)
        end else if (!write_strobe_n) begin
          nxt_op = SBC_WRITE; // see (RQ4)
        end else begin
          nxt_op = SBC_READ;
        end
      end
      default: nxt_op = SBC_IDLE;
    endcase
  end

  // Lane selects are sampled every counted edge of a write, also within a burst
  always_comb begin
    if (nxt_op == SBC_WRITE) begin
      nxt_lanes = ~byte_lane_write_sel_n; // see (RQ5)
    end else begin
      nxt_lanes = '0;
    end
  end

  always_comb begin
    burst.load       = edge_ok && !advance_or_load;
    burst.advance    = edge_ok && advance_or_load;
    burst.interleave = interleave_ff;
    burst.start_bits = addr[SBC_BURST_W-1:0];
  end

  sbc_burst_counter u_burst (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (burst)
  );

  // Strap is caught while reset is held, then left alone
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      interleave_ff <= burst_order_strap; // see (RQ11)
    end else begin
      interleave_ff <= interleave_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_op_ff <= SBC_IDLE;
    end else begin
      cmd_op_ff <= nxt_op; // see (RQ2)
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access_addr_ff <= '0;
    end else if (burst.load) begin
      access_addr_ff <= addr; // see (RQ1) see (RQ7)
    end else if (burst.advance) begin
      access_addr_ff[SBC_BURST_W-1:0] <= burst.next_bits; // see (RQ6)
    end else begin
      access_addr_ff <= access_addr_ff; // see (RQ10)
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lane_write_en_ff <= '0;
    end else if (edge_ok) begin
      lane_write_en_ff <= nxt_lanes; // see (RQ5)
    end else begin
      lane_write_en_ff <= lane_write_en_ff;
    end
  end

  // Data phase trails the command by one counted edge. The pins float
  // for a write, for a deselect, and for the first read after one,
  // which keeps a turnaround slot against the previous bus owner.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_op_ff     <= SBC_IDLE;
      data_lane_wr_ff <= '0;
      bus_drive_ok_ff <= 1'h0;
    end else if (edge_ok) begin
      phase_op_ff     <= cmd_op_ff;
      data_lane_wr_ff <= lane_write_en_ff; // see (RQ5)
      bus_drive_ok_ff <= (cmd_op_ff == SBC_READ) &&
                         (phase_op_ff != SBC_IDLE); // see (RQ12)
    end else begin
      phase_op_ff     <= phase_op_ff;
      data_lane_wr_ff <= data_lane_wr_ff;
      bus_drive_ok_ff <= bus_drive_ok_ff;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_counted_load;
    !clock_gate_n && !advance_or_load;
  endsequence

  sequence s_desel_cmd;
    s_counted_load and !select_now;
  endsequence

  sequence s_read_cmd;
    s_counted_load and select_now && write_strobe_n;
  endsequence

  a_masked_edge_hold: assert property ( // see (RQ3) see (RQ10)
    clock_gate_n |=> $stable(access_addr_ff) && $stable(cmd_op_ff)
                     && $stable(lane_write_en_ff))
    else $error("state moved on a masked edge");

  a_load_takes_addr: assert property ( // see (RQ7) see (RQ1)
    s_counted_load |=> access_addr_ff == $past(addr))
    else $error("load did not capture the address");

  a_advance_steps_low: assert property ( // see (RQ6)
    !clock_gate_n && advance_or_load
      |=> access_addr_ff[ADDR_W-1:SBC_BURST_W]
            == $past(access_addr_ff[ADDR_W-1:SBC_BURST_W])
          && access_addr_ff[SBC_BURST_W-1:0]
            != $past(access_addr_ff[SBC_BURST_W-1:0]))
    else $error("advance did not step the low bits only");

  a_select_decode: assert property ( // see (RQ9) see (RQ13)
    s_desel_cmd |=> cmd_op_ff == SBC_IDLE)
    else $error("bad select combination did not deselect");

  a_write_start: assert property ( // see (RQ4)
    s_counted_load and select_now && !write_strobe_n
      |=> cmd_op_ff == SBC_WRITE
          && lane_write_en_ff == ~$past(byte_lane_write_sel_n))
    else $error("write or lane enables not taken");

  a_lane_qualify: assert property ( // see (RQ5)
    s_read_cmd |=> lane_write_en_ff == '0)
    else $error("lane enabled without write strobe");

  a_lane_data_phase: assert property ( // see (RQ5)
    s_read_cmd ##1 !clock_gate_n |=> data_lane_wr_ff == '0)
    else $error("data phase lanes enabled for a read");

  a_desel_no_lanes: assert property ( // see (RQ5) see (RQ13)
    s_desel_cmd |=> lane_write_en_ff == '0)
    else $error("lanes enabled while deselected");

  a_float_deselected: assert property ( // see (RQ12)
    s_desel_cmd ##1 !clock_gate_n |=> !bus_drive_ok_ff)
    else $error("drove the bus while deselected");

  a_float_after_desel: assert property ( // see (RQ12)
    s_desel_cmd ##1 s_read_cmd |=> ##1 !bus_drive_ok_ff)
    else $error("drove the bus right after deselection");

  a_write_phase_float: assert property ( // see (RQ12)
    cmd_op_ff == SBC_WRITE && !clock_gate_n |=> !bus_drive_ok_ff)
    else $error("drove the bus in a write data phase");

  a_strap_steady: assert property ( // see (RQ11)
    $past(rst_n) |-> $stable(interleave_ff))
    else $error("burst order changed in operation");

endmodule // sbc_command_port
`default_nettype wire

// >>> sim/sbc_ctl_model.sv
// Controller model: drives the command port, one command per call.
// Assumes the bench calls issue with the clock running.
`timescale 1ns/1ps
`default_nettype none
module sbc_ctl_model
  import sbc_pkg::*;
(
  input  wire logic                  ref_clk,
  output logic                       clock_gate_n,
  output logic [SBC_ADDR_W-1:0]      addr,
  output logic [SBC_LANES-1:0]       byte_lane_write_sel_n,
  output logic                       write_strobe_n,
  output logic                       advance_or_load,
  output logic                       chip_sel_first_n,
  output logic                       chip_sel_second,
  output logic                       chip_sel_third_n
);
  logic desel;
  initial begin
    {clock_gate_n, addr, byte_lane_write_sel_n} = '0;
    {write_strobe_n, advance_or_load} = 2'h2;
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = 3'h4;
    desel = 1'b1;
  end
  // Inputs change at the falling edge; results seen 1 ns after the rise
  task automatic issue(input logic g, input logic [2:0] s, input logic we,
                       input logic adv, input logic [3:0] bw,
                       input logic [SBC_ADDR_W-1:0] a);
    @(negedge ref_clk);
    clock_gate_n = g;
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = s;
    write_strobe_n = we;
    // A fresh access always loads after a deselect
    advance_or_load = adv & ~desel;
    byte_lane_write_sel_n = bw;
    addr = a;
    @(posedge ref_clk);
    if (!g && !advance_or_load) begin
      desel = (s != 3'h2);
    end
    #1;
  endtask
endmodule // sbc_ctl_model
`default_nettype wire

// >>> sim/sync_burst_sram_command_port_bench.sv
// Bench for the command port: controller model plus scenario tasks.
// Assumes the design and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module sync_burst_sram_command_port_bench
  import sbc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b1;
  logic gate_n, we_n, adv, c1_n, c2, c3_n;
  logic [SBC_ADDR_W-1:0] a, acc;
  logic [SBC_LANES-1:0]  bw_n, len, dlw;
  sbc_op_t               op;
  logic                  ok, il;
  int                    err_total = 0;
  int                    check_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  sbc_ctl_model ctl (.ref_clk(ref_clk), .clock_gate_n(gate_n), .addr(a),
    .byte_lane_write_sel_n(bw_n), .write_strobe_n(we_n),
    .advance_or_load(adv), .chip_sel_first_n(c1_n),
    .chip_sel_second(c2), .chip_sel_third_n(c3_n));
  sbc_command_port DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .clock_gate_n(gate_n), .addr(a), .byte_lane_write_sel_n(bw_n),
    .write_strobe_n(we_n), .advance_or_load(adv),
    .chip_sel_first_n(c1_n), .chip_sel_second(c2),
    .chip_sel_third_n(c3_n), .burst_order_strap(strap),
    .access_addr_ff(acc), .cmd_op_ff(op), .lane_write_en_ff(len),
    .data_lane_wr_ff(dlw), .bus_drive_ok_ff(ok), .interleave_ff(il));
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset(input logic s);
    @(negedge ref_clk);
    rst_n = 1'b0;
    strap = s;
    repeat (3) @(negedge ref_clk);
    `CHK("rst op", SBC_IDLE, op);
    `CHK("rst addr", 21'h000000, acc);
    `CHK("rst lanes", 9'h000, {len, dlw, ok});
    `CHK("rst order", s, il);
    rst_n = 1'b1;
  endtask
  // Load, advance, a masked edge that must change nothing, then run on
  task automatic t_burst();
    logic [SBC_ADDR_W-1:0] nx;
    nx = 21'h1ffff5;
    nx[1:0] = strap ? 2'h0 : 2'h2;
    ctl.issue(1'b0, 3'h2, 1'b0, 1'b0, 4'he, 21'h1ffff5);
    `CHK("ld op", SBC_WRITE, op);
    `CHK("ld addr", 21'h1ffff5, acc);
    `CHK("ld lanes", 4'h1, len);
    ctl.issue(1'b0, 3'h2, 1'b0, 1'b1, 4'he, 21'h000a02);
    `CHK("adv addr", nx, acc);
    `CHK("adv op", SBC_WRITE, op);
    `CHK("adv data lanes", 4'h1, dlw);
    `CHK("wr float", 1'b0, ok);
    ctl.issue(1'b1, 3'h4, 1'b1, 1'b0, 4'h0, 21'h000123);
    `CHK("gate addr", nx, acc);
    `CHK("gate op", SBC_WRITE, op);
    ctl.issue(1'b0, 3'h2, 1'b0, 1'b1, 4'he, 21'h000000);
    `CHK("adv2 addr", 21'h1ffff7, acc);
    ctl.issue(1'b0, 3'h2, 1'b0, 1'b1, 4'he, 21'h000000);
    `CHK("adv3 addr", strap ? 21'h1ffff6 : 21'h1ffff4, acc);
  endtask
  // Each bad select mix deselects; reads then float one phase
  task automatic t_select();
    logic [2:0] bad [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    foreach (bad[i]) begin
      ctl.issue(1'b0, bad[i], 1'b1, 1'b0, 4'hf, 21'h000040);
      `CHK("desel op", SBC_IDLE, op);
    end
    // Advance asked right after deselection; the model must load instead
    ctl.issue(1'b0, 3'h2, 1'b1, 1'b1, 4'h0, 21'h000008);
    `CHK("rd op", SBC_READ, op);
    `CHK("rd addr", 21'h000008, acc);
    `CHK("rd lanes", 4'h0, len);
    `CHK("desel float", 1'b0, ok);
    ctl.issue(1'b0, 3'h2, 1'b1, 1'b0, 4'hf, 21'h000009);
    `CHK("first rd float", 1'b0, ok);
    ctl.issue(1'b0, 3'h2, 1'b1, 1'b1, 4'hf, 21'h000000);
    `CHK("second rd drive", 1'b1, ok);
    `CHK("rd adv addr", strap ? 21'h000008 : 21'h00000a, acc);
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  initial begin
    t_reset(1'b1);
    t_burst();
    t_select();
    t_reset(1'b0);
    t_burst();
    t_select();
    conclude();
  end
endmodule // sync_burst_sram_command_port_bench
`default_nettype wire
